// *** hdl/tsbl_defines.svh ***
// tile secure boot loader: offsets, field positions, reset values, timing
// assumes inclusion by bare name from the loader files
`ifndef TSBL_DEFINES_SVH
`define TSBL_DEFINES_SVH

// apb register byte offsets
`define TSBL_OFS_SEC        8'h00
`define TSBL_OFS_STATUS     8'h04
`define TSBL_OFS_PROG_ADDR  8'h08
`define TSBL_OFS_PROG_DATA  8'h0C
`define TSBL_OFS_PROG_CTL   8'h10
`define TSBL_OFS_CRC        8'h14
`define TSBL_OFS_RES_ADDR   8'h18
`define TSBL_OFS_RES_DATA   8'h1C
`define TSBL_OFS_RES_CTL    8'h20

// security register fields
`define TSBL_SEC_TAP_OFF    0
`define TSBL_SEC_LINK_OFF   1
`define TSBL_SEC_SECURE     5
`define TSBL_SEC_REDUND     7
`define TSBL_SEC_LOCK_LO    8
`define TSBL_SEC_LOCK_HI    11
`define TSBL_SEC_MASTER     12
`define TSBL_SEC_TAP_OTP    13
`define TSBL_SEC_DBG_OFF    14
`define TSBL_SEC_GP_LO      15
`define TSBL_SEC_GP_HI      21
`define TSBL_SEC_UID_LO     22
`define TSBL_SEC_UID_HI     31
`define TSBL_SEC_RESET      32'h0000_0000

// status register fields
`define TSBL_ST_RUN         0
`define TSBL_ST_FAIL        1
`define TSBL_ST_BYPASS      2
`define TSBL_ST_PROG_REF    3
`define TSBL_ST_SECURE      4

// programming control fields
`define TSBL_CTL_START      0
`define TSBL_CTL_TO_SEC     1

// otp geometry
`define TSBL_OTP_ROW_W      11
`define TSBL_OTP_SECT_LO    9
`define TSBL_OTP_SEC_ROW    11'h7FF

// programming port resource identifiers
`define TSBL_RES_ADDR       32'h0010_0200
`define TSBL_RES_DATA       32'h0020_0100
`define TSBL_RES_CTL        32'h0010_0300

// image check
`define TSBL_CRC_BYPASS     32'h0D15_AB1E
`define TSBL_CRC_POLY       32'hEDB8_8320
`define TSBL_CRC_PRELOAD    32'hFFFF_FFFF

// timing
`define TSBL_CLK_MHZ        125
`define TSBL_RST_SEQ_NS     15000
`define TSBL_RST_SEQ_CYC    ((`TSBL_RST_SEQ_NS * `TSBL_CLK_MHZ + 999) / 1000)

`endif

// *** hdl/tsbl_pkg.sv ***
// tile secure boot loader: shared types
// assumes nothing from the defines header, field widths are written out here
package tsbl_pkg;

    typedef enum logic [2:0] {
        TSBL_WAIT_LOCK = 3'b000,
        TSBL_RST_SEQ   = 3'b001,
        TSBL_SEC_LOAD  = 3'b010,
        TSBL_SEC_WAIT  = 3'b011,
        TSBL_LOAD      = 3'b100,
        TSBL_RUN       = 3'b101,
        TSBL_FAIL      = 3'b110
    } tsbl_state_type;

    typedef enum logic [1:0] {
        TSBL_PH_LEN  = 2'b00,
        TSBL_PH_PROG = 2'b01,
        TSBL_PH_CHK  = 2'b10
    } tsbl_phase_type;

    typedef struct packed {
        logic        to_sec;
        logic [15:0] addr;
        logic [31:0] data;
    } tsbl_prog_type;

endpackage

// *** hdl/tsbl_crc32.sv ***
// tile secure boot loader: byte-wide reflected crc-32 accumulator
// assumes one byte per enabled cycle, init restarts the remainder
`timescale 1ns/1ns
`include "tsbl_defines.svh"

module tsbl_crc32 #(
    parameter logic [31:0] POLY    = `TSBL_CRC_POLY,
    parameter logic [31:0] PRELOAD = `TSBL_CRC_PRELOAD
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        init,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [31:0] crc_reg
);

    logic [31:0] crc_next;

    // lsb-first shift per bit
    always_comb
    begin
        crc_next = crc_reg ^ {24'h00_0000, data};
        for (int i = 0; i < 8; i++)
        begin
            crc_next = crc_next[0] ? ((crc_next >> 1) ^ POLY) : (crc_next >> 1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            crc_reg <= 32'hFFFF_FFFF;
        else if (ce)
        begin
            if (init)
                crc_reg <= PRELOAD;
            else if (en)
                crc_reg <= crc_next;
        end
    end

endmodule

// *** hdl/tsbl_loader.sv ***
// tile secure boot loader: reset sequencing, security load, image load, apb
// assumes a synchronous otp word read port, a flash byte stream and a ram word port
`timescale 1ns/1ns
`include "tsbl_defines.svh"

module tsbl_loader #(
    parameter int RAM_AW = 16
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         ce,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         pll_locked,
    output logic                              gpio_pulldown_en,
    output logic                              otp_rd_req,
    output logic      [`TSBL_OTP_ROW_W-1:0]   otp_rd_addr,
    input  wire logic [31:0]                  otp_rd_data,
    input  wire logic                         otp_rd_valid,
    input  wire logic [7:0]                   flash_byte,
    input  wire logic                         flash_valid,
    output logic                              flash_ready,
    output logic                              ram_we,
    output logic      [RAM_AW-1:0]            ram_addr,
    output logic      [31:0]                  ram_wdata,
    output logic                              boot_start,
    output logic      [RAM_AW-1:0]            boot_addr,
    output logic                              boot_fail,
    output logic                              tap_block,
    output logic                              link_block,
    output logic                              otp_redundant_en,
    output logic                              tap_otp_block,
    output logic                              debug_sync_disable,
    output logic      [9:0]                   usercode_ext,
    input  wire logic                         tap_req,
    output logic                              tap_grant,
    output logic                              tap_refuse,
    input  wire logic                         link_req,
    output logic                              link_grant,
    output logic                              link_refuse,
    output logic                              otp_prog_req,
    output tsbl_pkg::tsbl_prog_type           otp_prog
);

    localparam logic [11:0] RST_CYC = 12'(`TSBL_RST_SEQ_CYC);

    tsbl_pkg::tsbl_state_type state_reg, state_next;
    tsbl_pkg::tsbl_phase_type phase_reg;
    logic [11:0]               rst_cnt_reg;
    logic [31:0]               sec_reg;
    logic                      loaded_reg;
    logic [31:0]               len_reg;
    logic [31:0]               word_reg;
    logic [31:0]               chk_reg;
    logic [31:0]               words_left_reg;
    logic [1:0]                bidx_reg;
    logic [31:0]               otp_buf_reg;
    logic [2:0]                otp_cnt_reg;
    logic                      otp_pend_reg;
    logic [`TSBL_OTP_ROW_W-1:0] otp_ptr_reg;
    logic                      bypass_reg;
    logic                      prog_ref_reg;
    logic [15:0]               prog_addr_reg;
    logic [31:0]               prog_data_reg;
    logic [31:0]               crc_reg;

    // source and byte stream
    wire        src_otp    = sec_reg[`TSBL_SEC_SECURE];
    wire        in_load    = (state_reg == tsbl_pkg::TSBL_LOAD);
    wire        byte_fire  = in_load & (src_otp ? (otp_cnt_reg != 3'h0) : (flash_ready & flash_valid));
    wire [7:0]  byte_val   = src_otp ? otp_buf_reg[7:0] : flash_byte;
    wire        word_end   = byte_fire & (bidx_reg == 2'h3);
    wire [31:0] shift_in   = {byte_val, word_reg[31:8]};
    wire [31:0] chk_full   = {byte_val, chk_reg[31:8]};
    wire        ph_len     = (phase_reg == tsbl_pkg::TSBL_PH_LEN);
    wire        ph_prog    = (phase_reg == tsbl_pkg::TSBL_PH_PROG);
    wire        ph_chk     = (phase_reg == tsbl_pkg::TSBL_PH_CHK);
    wire        crc_en     = byte_fire & ~ph_chk;
    wire        crc_init   = (state_reg == tsbl_pkg::TSBL_SEC_WAIT) & otp_rd_valid;
    wire        chk_done   = word_end & ph_chk;
    wire        is_bypass  = (chk_full == `TSBL_CRC_BYPASS);
    wire        crc_match  = (chk_full == ~crc_reg);
    wire        image_ok   = is_bypass | crc_match;
    wire        otp_need   = in_load & src_otp & (otp_cnt_reg == 3'h0) & ~otp_pend_reg & ~otp_rd_req;
    wire        sec_issue  = (state_reg == tsbl_pkg::TSBL_SEC_LOAD);

    // apb decode
    wire        apb_setup  = psel & ~penable & ~pready;
    wire        apb_acc    = psel & penable & pready;
    wire        apb_wr     = apb_acc & pwrite;
    wire        hit_sec    = (paddr == `TSBL_OFS_SEC);
    wire        hit_status = (paddr == `TSBL_OFS_STATUS);
    wire        hit_paddr  = (paddr == `TSBL_OFS_PROG_ADDR);
    wire        hit_pdata  = (paddr == `TSBL_OFS_PROG_DATA);
    wire        hit_pctl   = (paddr == `TSBL_OFS_PROG_CTL);
    wire        hit_crc    = (paddr == `TSBL_OFS_CRC);
    wire        hit_raddr  = (paddr == `TSBL_OFS_RES_ADDR);
    wire        hit_rdata  = (paddr == `TSBL_OFS_RES_DATA);
    wire        hit_rctl   = (paddr == `TSBL_OFS_RES_CTL);
    wire        hit_any    = hit_sec | hit_status | hit_paddr | hit_pdata | hit_pctl | hit_crc
                           | hit_raddr | hit_rdata | hit_rctl;
    wire [31:0] status_val = {27'h000_0000, src_otp, prog_ref_reg, bypass_reg, boot_fail, boot_start};
    wire [31:0] rd_val     = hit_sec    ? sec_reg
                           : hit_status ? status_val
                           : hit_paddr  ? {16'h0000, prog_addr_reg}
                           : hit_pdata  ? prog_data_reg
                           : hit_crc    ? ~crc_reg
                           : hit_raddr  ? `TSBL_RES_ADDR
                           : hit_rdata  ? `TSBL_RES_DATA
                           : hit_rctl   ? `TSBL_RES_CTL
                           : 32'h0000_0000;

    // programming request check
    wire        prog_go    = apb_wr & hit_pctl & pwdata[`TSBL_CTL_START];
    wire        prog_sec   = pwdata[`TSBL_CTL_TO_SEC];
    wire [1:0]  prog_sect  = prog_addr_reg[`TSBL_OTP_SECT_LO +: 2];
    wire [3:0]  sect_locks = sec_reg[`TSBL_SEC_LOCK_HI:`TSBL_SEC_LOCK_LO];
    wire        prog_deny  = sec_reg[`TSBL_SEC_MASTER] | (~prog_sec & sect_locks[prog_sect]);
    wire        ref_clr    = apb_wr & hit_status & pwdata[`TSBL_ST_PROG_REF];

    // security gates, blocked until the register is loaded
    wire        gate_tap   = ~loaded_reg | sec_reg[`TSBL_SEC_TAP_OFF];
    wire        gate_link  = ~loaded_reg | sec_reg[`TSBL_SEC_LINK_OFF];

    tsbl_crc32 u_crc (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .init    (crc_init),
        .en      (crc_en),
        .data    (byte_val),
        .crc_reg (crc_reg)
    );

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            tsbl_pkg::TSBL_WAIT_LOCK: if (pll_locked) state_next = tsbl_pkg::TSBL_RST_SEQ;
            tsbl_pkg::TSBL_RST_SEQ:   if (rst_cnt_reg == RST_CYC) state_next = tsbl_pkg::TSBL_SEC_LOAD;
            tsbl_pkg::TSBL_SEC_LOAD:  state_next = tsbl_pkg::TSBL_SEC_WAIT;
            tsbl_pkg::TSBL_SEC_WAIT:  if (otp_rd_valid) state_next = tsbl_pkg::TSBL_LOAD;
            tsbl_pkg::TSBL_LOAD:      if (chk_done) state_next = image_ok ? tsbl_pkg::TSBL_RUN
                                                                          : tsbl_pkg::TSBL_FAIL;
            tsbl_pkg::TSBL_RUN:       state_next = tsbl_pkg::TSBL_RUN;
            tsbl_pkg::TSBL_FAIL:      state_next = tsbl_pkg::TSBL_FAIL;
            default:                  state_next = tsbl_pkg::TSBL_WAIT_LOCK;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg        <= tsbl_pkg::TSBL_WAIT_LOCK;
            rst_cnt_reg      <= 12'h000;
            gpio_pulldown_en <= 1'b1;
        end
        else if (ce)
        begin
            state_reg   <= state_next;
            rst_cnt_reg <= (state_reg == tsbl_pkg::TSBL_RST_SEQ) ? rst_cnt_reg + 12'h001 : 12'h000;
            if (state_reg == tsbl_pkg::TSBL_SEC_LOAD)
                gpio_pulldown_en <= 1'b0;
        end
    end

    // security register load and software field
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_reg    <= `TSBL_SEC_RESET;
            loaded_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (crc_init)
            begin
                sec_reg    <= otp_rd_data;
                loaded_reg <= 1'b1;
            end
            else if (apb_wr & hit_sec)
                sec_reg[`TSBL_SEC_GP_HI:`TSBL_SEC_GP_LO] <= pwdata[`TSBL_SEC_GP_HI:`TSBL_SEC_GP_LO];
        end
    end

    // otp word reads: security row first, then image from row 0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            otp_rd_req   <= 1'b0;
            otp_rd_addr  <= '0;
            otp_pend_reg <= 1'b0;
            otp_ptr_reg  <= '0;
        end
        else if (ce)
        begin
            otp_rd_req <= sec_issue | otp_need;
            if (sec_issue)
                otp_rd_addr <= `TSBL_OTP_SEC_ROW;
            else if (otp_need)
            begin
                otp_rd_addr <= otp_ptr_reg;
                otp_ptr_reg <= otp_ptr_reg + 1'b1;
            end
            if (sec_issue | otp_need)
                otp_pend_reg <= 1'b1;
            else if (otp_rd_valid)
                otp_pend_reg <= 1'b0;
        end
    end

    // otp word split into bytes, low byte first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            otp_buf_reg <= 32'h0000_0000;
            otp_cnt_reg <= 3'h0;
        end
        else if (ce)
        begin
            if (in_load & otp_rd_valid)
            begin
                otp_buf_reg <= otp_rd_data;
                otp_cnt_reg <= 3'h4;
            end
            else if (byte_fire & src_otp)
            begin
                otp_buf_reg <= {8'h00, otp_buf_reg[31:8]};
                otp_cnt_reg <= otp_cnt_reg - 3'h1;
            end
        end
    end

    // flash byte handshake
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flash_ready <= 1'b0;
        else if (ce)
            flash_ready <= (state_next == tsbl_pkg::TSBL_LOAD) & ~src_otp & ~crc_init & ~chk_done;
    end

    // image parse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_reg      <= tsbl_pkg::TSBL_PH_LEN;
            bidx_reg       <= 2'h0;
            word_reg       <= 32'h0000_0000;
            len_reg        <= 32'h0000_0000;
            chk_reg        <= 32'h0000_0000;
            words_left_reg <= 32'h0000_0000;
        end
        else if (ce & byte_fire)
        begin
            bidx_reg <= bidx_reg + 2'h1;
            word_reg <= shift_in;
            if (ph_chk)
                chk_reg <= chk_full;
            if (word_end & ph_len)
            begin
                len_reg        <= shift_in;
                words_left_reg <= shift_in;
                phase_reg      <= (shift_in == 32'h0000_0000) ? tsbl_pkg::TSBL_PH_CHK
                                                              : tsbl_pkg::TSBL_PH_PROG;
            end
            else if (word_end & ph_prog)
            begin
                words_left_reg <= words_left_reg - 32'h0000_0001;
                if (words_left_reg == 32'h0000_0001)
                    phase_reg <= tsbl_pkg::TSBL_PH_CHK;
            end
        end
    end

    // ram writes from the lowest address, start at the same address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ram_we     <= 1'b0;
            ram_addr   <= '0;
            ram_wdata  <= 32'h0000_0000;
            boot_start <= 1'b0;
            boot_addr  <= '0;
            boot_fail  <= 1'b0;
            bypass_reg <= 1'b0;
        end
        else if (ce)
        begin
            ram_we <= word_end & ph_prog;
            if (ram_we)
                ram_addr <= ram_addr + 1'b1;
            if (word_end & ph_prog)
                ram_wdata <= shift_in;
            if (chk_done)
            begin
                boot_start <= image_ok;
                boot_fail  <= ~image_ok;
                bypass_reg <= is_bypass;
                boot_addr  <= '0;
            end
        end
    end

    // security-gated outputs and access answers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tap_block          <= 1'b1;
            link_block         <= 1'b1;
            otp_redundant_en   <= 1'b0;
            tap_otp_block      <= 1'b1;
            debug_sync_disable <= 1'b1;
            usercode_ext       <= 10'h000;
            tap_grant          <= 1'b0;
            tap_refuse         <= 1'b0;
            link_grant         <= 1'b0;
            link_refuse        <= 1'b0;
        end
        else if (ce)
        begin
            tap_block          <= gate_tap;
            link_block         <= gate_link;
            otp_redundant_en   <= loaded_reg & sec_reg[`TSBL_SEC_REDUND];
            tap_otp_block      <= ~loaded_reg | sec_reg[`TSBL_SEC_TAP_OTP];
            debug_sync_disable <= ~loaded_reg | sec_reg[`TSBL_SEC_DBG_OFF];
            usercode_ext       <= sec_reg[`TSBL_SEC_UID_HI:`TSBL_SEC_UID_LO];
            tap_grant          <= tap_req & ~gate_tap;
            tap_refuse         <= tap_req & gate_tap;
            link_grant         <= link_req & ~gate_link;
            link_refuse        <= link_req & gate_link;
        end
    end

    // programming ports
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prog_addr_reg <= 16'h0000;
            prog_data_reg <= 32'h0000_0000;
            prog_ref_reg  <= 1'b0;
            otp_prog_req  <= 1'b0;
            otp_prog      <= '0;
        end
        else if (ce)
        begin
            if (apb_wr & hit_paddr)
                prog_addr_reg <= pwdata[15:0];
            if (apb_wr & hit_pdata)
                prog_data_reg <= pwdata;
            otp_prog_req <= prog_go & ~prog_deny;
            if (prog_go & ~prog_deny)
                otp_prog <= '{to_sec: prog_sec, addr: prog_addr_reg, data: prog_data_reg};
            if (prog_go & prog_deny)
                prog_ref_reg <= 1'b1;
            else if (ref_clr)
                prog_ref_reg <= 1'b0;
        end
    end

    // apb slave, no wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~hit_any;
            if (apb_setup & ~pwrite)
                prdata <= rd_val;
        end
    end

endmodule

// *** tb/tsbl_loader_assertions.sv ***
// tile secure boot loader: port checks on the loader
// assumes bind to tsbl_loader with ce held high
`timescale 1ns/1ns

module tsbl_loader_assertions #(
    parameter int RAM_AW = 16
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              tap_req,
    input wire logic              tap_block,
    input wire logic              tap_grant,
    input wire logic              tap_refuse,
    input wire logic              link_req,
    input wire logic              link_block,
    input wire logic              link_grant,
    input wire logic              link_refuse,
    input wire logic              boot_start,
    input wire logic              boot_fail,
    input wire logic              gpio_pulldown_en,
    input wire logic [RAM_AW-1:0] boot_addr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup; psel && !penable && !pready; endsequence
    sequence one_pulse; pready ##1 !pready; endsequence
    apb_answer_a: assert property (apb_setup |=> one_pulse) else $error("apb answer wrong");
    tap_refuse_a: assert property (tap_req && tap_block |=> tap_refuse && !tap_grant) else $error("tap open");
    tap_grant_a: assert property (tap_req && !tap_block |=> tap_grant && !tap_refuse) else $error("tap shut");
    link_answer_a: assert property (link_req |=> link_refuse == $past(link_block) && link_grant != $past(link_block))
        else $error("link answer wrong");
    boot_origin_a: assert property (boot_start |-> boot_addr == '0) else $error("boot address not zero");
    outcome_excl_a: assert property (!(boot_start && boot_fail)) else $error("start with failure");
    fail_sticky_a: assert property (boot_fail |=> boot_fail && !boot_start) else $error("failure released");
    pulldown_rel_a: assert property ($rose(presetn) |-> gpio_pulldown_en) else $error("pull-down dropped");
endmodule

bind tsbl_loader tsbl_loader_assertions #(.RAM_AW(RAM_AW)) tsbl_loader_assertions_inst (.*);

// *** tb/tsbl_partner.sv ***
// tile secure boot loader: otp array and serial flash byte source
// assumes the bench loads img, nb, sec and slow while reset is low
`timescale 1ns/1ns

module tsbl_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        otp_rd_req,
    input  wire logic        flash_ready,
    input  wire logic [10:0] otp_rd_addr,
    output logic      [31:0] otp_rd_data,
    output logic             otp_rd_valid,
    output logic             flash_valid,
    output logic      [7:0]  flash_byte
);
    logic [7:0]  img [0:15];
    logic [31:0] sec;
    logic [10:0] row;
    logic        pend, tg, slow;
    int          idx, nb;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {pend, tg, otp_rd_valid, flash_valid, row} <= '0;
            idx <= 0;
            otp_rd_data <= 32'h0;
            flash_byte <= 8'h00;
        end
        else
        begin
            pend <= otp_rd_req;
            row <= otp_rd_req ? otp_rd_addr : row;
            otp_rd_valid <= pend;
            // rows 0-3 hold the same image as the flash, low byte first
            otp_rd_data <= pend ? (row == 11'h7FF ? sec : {img[{row[1:0], 2'h3}], img[{row[1:0], 2'h2}],
                img[{row[1:0], 2'h1}], img[{row[1:0], 2'h0}]}) : ~otp_rd_data;
            tg <= ~tg;
            if (flash_valid && flash_ready)
            begin
                idx <= idx + 1;
                flash_valid <= 1'b0;
                flash_byte <= ~flash_byte;
            end
            else if (idx < nb && (!slow || tg))
            begin
                flash_valid <= 1'b1;
                flash_byte <= img[idx];
            end
        end
    end
endmodule

// *** tb/tsbl_loader_bench.sv ***
// tile secure boot loader: bench over apb, reset and tap/link requests
// assumes the loader, its checker bind and the partner model
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: got %h", $time, a); end end

module tsbl_loader_bench;
    logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pll_locked = 0, tap_req = 0;
    logic        link_req = 0, pready, pslverr, gpio_pulldown_en, otp_rd_req, otp_rd_valid, flash_valid, err;
    logic        ram_we, boot_start, boot_fail, tap_block, link_block, otp_redundant_en, tap_otp_block;
    logic        debug_sync_disable, tap_grant, tap_refuse, link_grant, link_refuse, otp_prog_req, flash_ready;
    logic        prog_seen = 0;
    logic [7:0]  paddr = 0, flash_byte;
    logic [9:0]  usercode_ext;
    logic [10:0] otp_rd_addr;
    logic [15:0] ram_addr, boot_addr;
    logic [31:0] pwdata = 0, prdata, otp_rd_data, ram_wdata, rd, mem [0:3];
    tsbl_pkg::tsbl_prog_type otp_prog;
    int          num_errors = 0, compares = 0;

    tsbl_loader tsbl_loader_inst (.*);
    tsbl_partner tsbl_partner_inst (.*);

    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) if (ram_we) mem[ram_addr[1:0]] <= ram_wdata;
    always @(posedge pclk) prog_seen <= presetn & (prog_seen | otp_prog_req);

    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h0, b};
        repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
        return c;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 9 && pready !== 1'b1; n++) @(posedge pclk);
        if (n == 9) begin num_errors++; wrap_up; end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic run(input logic [31:0] sec, input int mode);
        logic [31:0] c, g;
        int n;
        @(posedge pclk);
        {presetn, pll_locked} <= 2'b00;
        {tsbl_partner_inst.sec, tsbl_partner_inst.slow, tsbl_partner_inst.nb} = {sec, mode[0], 32'd16};
        c = 32'hFFFF_FFFF;
        for (n = 0; n < 12; n++)
        begin
            tsbl_partner_inst.img[n] = n < 4 ? {6'h0, n == 0, 1'b0} : 8'(16 * n + mode);
            c = crc8(c, tsbl_partner_inst.img[n]);
        end
        g = ~c;
        c = mode == 1 ? 32'h0D15_AB1E : mode == 2 ? c : g;
        for (n = 0; n < 4; n++) tsbl_partner_inst.img[12 + n] = c[8 * n +: 8];
        repeat (16) @(posedge pclk);
        `CHK(gpio_pulldown_en, 1'b1)
        presetn <= 1'b1;
        {tap_req, link_req} <= 2'b11;
        @(posedge pclk);
        {tap_req, link_req, pll_locked} <= 3'b001;
        for (n = 0; n < 20000 && boot_start !== 1'b1 && boot_fail !== 1'b1; n++) @(posedge pclk);
        if (n == 20000) begin num_errors++; wrap_up; end
        `CHK(boot_fail, mode == 2)
        if (mode != 2) `CHK({mem[1], mem[0]}, 64'hB0A0_9080_7060_5040 + {8{8'(mode)}})
        `CHK({debug_sync_disable, tap_otp_block, otp_redundant_en, link_block, tap_block, usercode_ext},
            {sec[14], sec[13], sec[7], sec[1], sec[0], sec[31:22]})
        apb(0, 8'h00, 0);
        `CHK(rd, sec)
        apb(0, 8'h14, 0);
        `CHK(rd, g)
        apb(1, 8'h08, 32'h0200);
        apb(1, 8'h10, 32'h1);
        apb(0, 8'h04, 0);
        `CHK(rd[4:0], {sec[5], sec[9] | sec[12], mode == 1, mode == 2, mode != 2})
        `CHK({prog_seen, otp_prog}, (sec[9] | sec[12]) ? 50'h0 : {2'b10, 16'h0200, 32'h0})
        {tap_req, link_req} <= 2'b11;
        @(posedge pclk);
        {tap_req, link_req} <= 2'b00;
    endtask

    initial
    begin
        run(32'h0000_0000, 0);
        apb(1, 8'h00, 32'hFFFF_FFFF);
        apb(0, 8'h00, 0);
        `CHK(rd, 32'h003F_8000)
        apb(0, 8'h1C, 0);
        `CHK(rd, 32'h0020_0100)
        apb(0, 8'h40, 0);
        `CHK(err, 1'b1)
        run(32'hA5C0_2282, 1);
        run(32'h0000_5001, 2);
        run(32'h0000_0C20, 0);
        wrap_up;
    end
endmodule
